// ### logic/lcpj_config.sv
// Per-channel transmit scale, pulse template RAM with indirect access, and receive jitter attenuator setup.
// Assumes a host control port synchronous to core_clk_i and a waveform shaper reading the template.
`include "lcpj_defines.svh"
`default_nettype none

// What this block does
// - Holds six-bit amplitude scale, reset 100001, applied to user pulses.
// - T1 short haul, J1, DS1 0 dB: nominal scale 110110, step 2%.
// - DS1 -7.5 dB: nominal scale 010001, step 6.25%.
// - DS1 -15 dB: nominal scale 001000, step 12.5%.
// - DS1 -22.5 dB: nominal scale 000100, step 25%.
// - E1 75 or 120 ohm: nominal scale 100001, step 3%.
// - Writing one to access bit 7 launches one template RAM access.
// - Access bit 6 picks direction: zero writes, one reads.
// - Access bits 5-4 pick one of four unit intervals.
// - Access bits 3-0 pick one of sixteen samples.
// - Indirect write stores data bits 6-0 into the addressed sample.
// - Indirect read returns the sample amplitude in data bits 6-0.
// - Jitter bit 5: real time versus peak accumulation measurement.
// - Jitter bit 4, reset one: wide bandwidth limit mode.
// - Jitter bit 3 puts the attenuator in the receive path.
// - Jitter bits 2-1 set depth 128, 64 or 32 bits.
// - Jitter bit 0 selects the lower loop corner frequency.
module lcpj_config #(
    parameter logic [3:0] CHANNEL   = 4'h0,
    parameter int         UI_W      = 2,
    parameter int         SAMPLE_INDEX_W    = 4,
    parameter int         AMP_W     = 7,
    parameter int         SCALE_W   = 6
) (
    // Clock and reset
    input  wire logic                 core_clk_i,
    input  wire logic                 reset_i,
    // Host control port
    input  wire logic [11:0]          host_addr_i,
    input  wire logic                 host_wr_i,
    input  wire logic                 host_rd_i,
    input  wire lcpj_pkg::lcpj_byte_type host_wdata_i,
    output var  lcpj_pkg::lcpj_byte_type host_rdata_o,
    output logic                      host_rdata_valid_o,
    // Template selection from the transmit setup
    input  wire logic [3:0]           template_select_i,
    // Waveform shaper side
    input  wire logic [UI_W+SAMPLE_INDEX_W-1:0] shaper_addr_i,
    output logic [AMP_W+SCALE_W-1:0]  shaper_sample_o,
    output logic [SCALE_W-1:0]        amplitude_scale_o,
    output logic [SCALE_W-1:0]        nominal_scale_o,
    output logic [11:0]               scale_step_o,
    output logic                      access_busy_o,
    // Receive jitter attenuator setup
    output logic                      jitter_measure_mode_o,
    output logic                      atten_wide_bw_mode_o,
    output logic                      rx_atten_enable_o,
    output logic [1:0]                rx_atten_depth_o,
    output logic [7:0]                rx_atten_depth_bits_o,
    output logic                      rx_atten_corner_select_o
);
    import lcpj_pkg::*;

    localparam int ADDR_W = UI_W + SAMPLE_INDEX_W;
    localparam int DEPTH  = 1 << ADDR_W;

    // Registers
    logic [SCALE_W-1:0]     scale_reg;
    logic [SCALE_W-1:0]     scale_next;
    logic [7:0]             access_reg;
    logic [7:0]             access_next;
    logic [AMP_W-1:0]       data_reg;
    logic [AMP_W-1:0]       data_next;
    logic                   meas_reg;
    logic                   wide_reg;
    logic                   jen_reg;
    logic [1:0]             depth_reg;
    logic                   corner_reg;
    lcpj_state_type         state_reg;
    lcpj_state_type         state_next;
    logic [AMP_W-1:0]       ram_rd_reg;
    logic [AMP_W-1:0]       tpl_ram [DEPTH];

    // Address decode
    wire logic              chan_hit;
    wire logic [3:0]        reg_chan;
    wire logic [7:0]        reg_offset;
    wire logic              hit_scale;
    wire logic              hit_access;
    wire logic              hit_data;
    wire logic              hit_jitter;
    wire logic              wr_scale;
    wire logic              wr_access;
    wire logic              wr_data;
    wire logic              wr_jitter;
    wire logic              idle;
    wire logic              in_run;
    wire logic              in_fin;
    wire logic              busy_next;
    wire logic              launch;
    wire logic              dir_read;
    wire logic [ADDR_W-1:0] ram_addr;
    wire logic              ram_we;
    wire logic              user_tpl;
    wire logic [7:0]        rd_mux;
    wire logic [7:0]        depth_bits;
    wire logic [AMP_W+SCALE_W-1:0] scaled;
    wire logic [AMP_W-1:0]  shaper_raw;
    wire logic [AMP_W+SCALE_W-1:0] shaper_wide;
    wire logic [AMP_W+SCALE_W-1:0] shaper_next;
    wire logic [7:0]        rdata_next;

    // The channel digit sits above the offset byte, so every channel decodes the same offsets
    assign reg_chan   = host_addr_i[`LCPJ_CHAN_HI:`LCPJ_CHAN_LO];
    assign reg_offset = host_addr_i[`LCPJ_OFS_HI:`LCPJ_OFS_LO];
    assign chan_hit   = reg_chan == CHANNEL;
    assign hit_scale  = chan_hit && reg_offset == `LCPJ_OFS_SCALE;
    assign hit_access = chan_hit && reg_offset == `LCPJ_OFS_ACCESS;
    assign hit_data   = chan_hit && reg_offset == `LCPJ_OFS_DATA;
    assign hit_jitter = chan_hit && reg_offset == `LCPJ_OFS_JITTER;
    assign wr_scale   = host_wr_i && hit_scale;
    assign wr_access  = host_wr_i && hit_access;
    assign wr_data    = host_wr_i && hit_data;
    assign wr_jitter  = host_wr_i && hit_jitter;
    assign idle       = state_reg == LCPJ_IDLE;
    assign in_run     = state_reg == LCPJ_RUN;
    assign in_fin     = state_reg == LCPJ_FIN;
    // Busy is flopped from the next state, so it rises on the launch edge itself
    assign busy_next  = state_next != LCPJ_IDLE;

    // launch on one
    // Writes to the access register during an access are dropped so the address cannot shift mid-flight
    assign launch     = wr_access && idle && host_wdata_i[`LCPJ_ACC_GO_BIT];

    assign dir_read   = access_reg[`LCPJ_ACC_DIR_BIT];

    assign ram_addr   = {access_reg[`LCPJ_ACC_UI_HI:`LCPJ_ACC_UI_LO],
                         access_reg[`LCPJ_ACC_SAMPLE_INDEX_HI:`LCPJ_ACC_SAMPLE_INDEX_LO]};

    assign ram_we     = in_run && !dir_read;

    // Access sequencer
    // RUN touches the RAM, FIN clears the launch bit and lands a read result
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            LCPJ_IDLE: begin
                if (launch) begin
                    state_next = LCPJ_RUN;
                end
            end
            LCPJ_RUN: begin
                state_next = LCPJ_FIN;
            end
            LCPJ_FIN: begin
                state_next = LCPJ_IDLE;
            end
            default: begin
                state_next = LCPJ_IDLE;
            end
        endcase
    end

    // Access register next value
    always_comb begin
        access_next = access_reg;
        if (wr_access && idle) begin
            access_next = host_wdata_i;
        end
        if (in_fin) begin
            access_next[`LCPJ_ACC_GO_BIT] = 1'b0;
        end
    end

    // Data register next value
    always_comb begin
        data_next = data_reg;
        if (wr_data) begin
            data_next = host_wdata_i[AMP_W-1:0];
        end
        // read result loaded
        // The read result wins over a host write landing in the same cycle
        if (in_fin && dir_read) begin
            data_next = ram_rd_reg;
        end
    end

    assign scale_next = wr_scale ? host_wdata_i[SCALE_W-1:0] : scale_reg;

    assign depth_bits = (depth_reg == `LCPJ_DEPTH_128) ? `LCPJ_BITS_128 :
                        (depth_reg == `LCPJ_DEPTH_64)  ? `LCPJ_BITS_64  :
                                                         `LCPJ_BITS_32;

    // Register read mux; reserved bits and unmapped offsets read zero
    assign rd_mux = hit_scale  ? {{(8-SCALE_W){1'b0}}, scale_reg} :
                    hit_access ? access_reg :
                    hit_data   ? {{(8-AMP_W){1'b0}}, data_reg} :
                    hit_jitter ? {2'h0, meas_reg, wide_reg, jen_reg, depth_reg, corner_reg} :
                                 `LCPJ_ZERO8;

    // scale applied
    // Only the user-programmable templates are scaled; built-in templates pass unscaled
    assign user_tpl = template_select_i[3:2] == `LCPJ_TPL_USER_HI;

    // Clocked state
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_reg  <= LCPJ_IDLE;
            scale_reg  <= `LCPJ_RST_SCALE;
            access_reg <= `LCPJ_RST_ACCESS;
            data_reg   <= `LCPJ_RST_DATA;
        end else begin
            state_reg  <= state_next;
            scale_reg  <= scale_next;
            access_reg <= access_next;
            data_reg   <= data_next;
        end
    end

    // Setup only; the attenuator itself sits in the receive path
    // measurement mode
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            meas_reg   <= 1'b0;
            wide_reg   <= `LCPJ_RST_WIDE;
            jen_reg    <= 1'b0;
            depth_reg  <= `LCPJ_RST_DEPTH;
            corner_reg <= 1'b0;
        end else if (wr_jitter) begin
            meas_reg   <= host_wdata_i[`LCPJ_JA_MEAS_BIT];
            wide_reg   <= host_wdata_i[`LCPJ_JA_WIDE_BIT];
            jen_reg    <= host_wdata_i[`LCPJ_JA_EN_BIT];
            depth_reg  <= host_wdata_i[`LCPJ_JA_DEPTH_HI:`LCPJ_JA_DEPTH_LO];
            corner_reg <= host_wdata_i[`LCPJ_JA_CORNER_BIT];
        end
    end

    // Template RAM; contents are not reset and must be loaded before a user template is selected
    always_ff @(posedge core_clk_i) begin
        if (ram_we) begin
            tpl_ram[ram_addr] <= data_reg;
        end
    end

    // Registered read port; the address has settled a cycle before FIN takes the word
    always_ff @(posedge core_clk_i) begin
        ram_rd_reg <= tpl_ram[ram_addr];
    end

    // Both operands are widened to the product width, so no scale code can wrap the sample
    assign shaper_raw  = tpl_ram[shaper_addr_i];
    assign shaper_wide = {{SCALE_W{1'b0}}, shaper_raw};
    assign scaled      = shaper_wide * {{AMP_W{1'b0}}, scale_reg};
    assign shaper_next = user_tpl ? scaled : shaper_wide;

    // Read data is zero outside a read, so the channels of a shared bus can be ORed together
    assign rdata_next  = host_rd_i ? rd_mux : `LCPJ_ZERO8;

    // Shaper sample and host read data
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            shaper_sample_o    <= `LCPJ_ZERO13;
            host_rdata_o       <= `LCPJ_ZERO8;
            host_rdata_valid_o <= 1'b0;
        end else begin
            shaper_sample_o    <= shaper_next;
            host_rdata_o       <= rdata_next;
            host_rdata_valid_o <= host_rd_i;
        end
    end

    // Nominal scale for the selected template
    // Steps are reported in hundredths of a percent for the shaper
    logic [SCALE_W-1:0] nom_sel;
    logic [11:0]        step_sel;

    always_comb begin
        nom_sel  = `LCPJ_NOM_T1;
        step_sel = `LCPJ_STEP_T1;
        unique case (template_select_i)
            `LCPJ_TPL_E1_75, `LCPJ_TPL_E1_120: begin
                nom_sel  = `LCPJ_NOM_E1;
                step_sel = `LCPJ_STEP_E1;
            end
            `LCPJ_TPL_DS1_7DB5: begin
                nom_sel  = `LCPJ_NOM_7DB5;
                step_sel = `LCPJ_STEP_7DB5;
            end
            `LCPJ_TPL_DS1_15DB: begin
                nom_sel  = `LCPJ_NOM_15DB;
                step_sel = `LCPJ_STEP_15DB;
            end
            `LCPJ_TPL_DS1_22DB5: begin
                nom_sel  = `LCPJ_NOM_22DB5;
                step_sel = `LCPJ_STEP_22DB5;
            end
            default: begin
                nom_sel  = `LCPJ_NOM_T1;
                step_sel = `LCPJ_STEP_T1;
            end
        endcase
    end

    // Output flops
    // Every output is a flop so downstream timing never sees the decode logic
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            amplitude_scale_o        <= `LCPJ_RST_SCALE;
            nominal_scale_o          <= `LCPJ_NOM_E1;
            scale_step_o             <= `LCPJ_STEP_E1;
            access_busy_o            <= 1'b0;
            jitter_measure_mode_o    <= 1'b0;
            atten_wide_bw_mode_o     <= `LCPJ_RST_WIDE;
            rx_atten_enable_o        <= 1'b0;
            rx_atten_depth_o         <= `LCPJ_RST_DEPTH;
            rx_atten_depth_bits_o    <= `LCPJ_BITS_128;
            rx_atten_corner_select_o <= 1'b0;
        end else begin
            amplitude_scale_o        <= scale_next;
            nominal_scale_o          <= nom_sel;
            scale_step_o             <= step_sel;
            access_busy_o            <= busy_next;
            jitter_measure_mode_o    <= meas_reg;
            atten_wide_bw_mode_o     <= wide_reg;
            rx_atten_enable_o        <= jen_reg;
            rx_atten_depth_o         <= depth_reg;
            rx_atten_depth_bits_o    <= depth_bits;
            rx_atten_corner_select_o <= corner_reg;
        end
    end

endmodule : lcpj_config

`default_nettype wire

// ### logic/lcpj_defines.svh
// Offsets, field positions, reset values and nominal scale codes of the channel configuration bank.
// Assumes the includer sits inside a module or package that needs these names.
`ifndef LCPJ_DEFINES_SVH
`define LCPJ_DEFINES_SVH

// Host address: channel digit above the offset byte of each register
`define LCPJ_CHAN_HI         11
`define LCPJ_CHAN_LO         8
`define LCPJ_OFS_HI          7
`define LCPJ_OFS_LO          0
`define LCPJ_OFS_SCALE       8'h24
`define LCPJ_OFS_ACCESS      8'h25
`define LCPJ_OFS_DATA        8'h26
`define LCPJ_OFS_JITTER      8'h27

// Access register fields
`define LCPJ_ACC_GO_BIT      7
`define LCPJ_ACC_DIR_BIT     6
`define LCPJ_ACC_UI_HI       5
`define LCPJ_ACC_UI_LO       4
`define LCPJ_ACC_SAMPLE_INDEX_HI     3
`define LCPJ_ACC_SAMPLE_INDEX_LO     0

// Jitter attenuator register fields
`define LCPJ_JA_MEAS_BIT     5
`define LCPJ_JA_WIDE_BIT     4
`define LCPJ_JA_EN_BIT       3
`define LCPJ_JA_DEPTH_HI     2
`define LCPJ_JA_DEPTH_LO     1
`define LCPJ_JA_CORNER_BIT   0

// Reset values
`define LCPJ_RST_SCALE       6'h21
`define LCPJ_RST_ACCESS      8'h00
`define LCPJ_RST_DATA        7'h00
`define LCPJ_RST_WIDE        1'b1
`define LCPJ_RST_DEPTH       2'h0

// Depth codes and buffer sizes in bits
`define LCPJ_DEPTH_128       2'h0
`define LCPJ_DEPTH_64        2'h1
`define LCPJ_BITS_128        8'h80
`define LCPJ_BITS_64         8'h40
`define LCPJ_BITS_32         8'h20

// Template select codes and nominal scales; steps are in hundredths of a percent
`define LCPJ_TPL_E1_75       4'h0
`define LCPJ_TPL_E1_120      4'h1
`define LCPJ_TPL_DS1_0DB     4'h8
`define LCPJ_TPL_DS1_7DB5    4'h9
`define LCPJ_TPL_DS1_15DB    4'ha
`define LCPJ_TPL_DS1_22DB5   4'hb
`define LCPJ_TPL_USER_HI     2'h3
`define LCPJ_NOM_T1          6'h36
`define LCPJ_NOM_7DB5        6'h11
`define LCPJ_NOM_15DB        6'h08
`define LCPJ_NOM_22DB5       6'h04
`define LCPJ_NOM_E1          6'h21
`define LCPJ_STEP_T1         12'h0c8
`define LCPJ_STEP_7DB5       12'h271
`define LCPJ_STEP_15DB       12'h4e2
`define LCPJ_STEP_22DB5      12'h9c4
`define LCPJ_STEP_E1         12'h12c

`define LCPJ_ZERO8           8'h00
`define LCPJ_ZERO13          13'h0000

`endif

// ### logic/lcpj_pkg.sv
// Types shared by the channel configuration bank.
// Assumes lcpj_defines.svh holds the numeric constants.
`default_nettype none

package lcpj_pkg;

    typedef enum logic [1:0] {
        LCPJ_IDLE = 2'b00,
        LCPJ_RUN  = 2'b01,
        LCPJ_FIN  = 2'b10
    } lcpj_state_type;

    typedef logic [7:0] lcpj_byte_type;

endpackage : lcpj_pkg

`default_nettype wire

// ### tb/lcpj_config_props.sv
// Concurrent checks on the ports of the channel configuration bank.
// Assumes it is bound into every lcpj_config instance.
`default_nettype none
module lcpj_config_props #(
    parameter logic [3:0] CHANNEL = 4'h0,
    parameter int         SCALE_W = 6
) (
    input wire logic                    core_clk_i,
    input wire logic                    reset_i,
    input wire logic [11:0]             host_addr_i,
    input wire logic                    host_wr_i,
    input wire lcpj_pkg::lcpj_byte_type host_wdata_i,
    input wire logic [3:0]              template_select_i,
    input wire logic [SCALE_W-1:0]      amplitude_scale_o,
    input wire logic [SCALE_W-1:0]      nominal_scale_o,
    input wire logic [11:0]             scale_step_o,
    input wire logic                    access_busy_o,
    input wire logic                    jitter_measure_mode_o,
    input wire logic                    atten_wide_bw_mode_o,
    input wire logic                    rx_atten_enable_o,
    input wire logic [1:0]              rx_atten_depth_o,
    input wire logic [7:0]              rx_atten_depth_bits_o,
    input wire logic                    rx_atten_corner_select_o
);
    timeunit 1ns;
    timeprecision 100ps;
    import lcpj_pkg::*;
    logic wr_ja;
    assign wr_ja = host_wr_i && host_addr_i == {CHANNEL, 8'h27};
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);

    chk_scale_write: assert property (host_wr_i && host_addr_i == {CHANNEL, 8'h24}
        |=> amplitude_scale_o == $past(host_wdata_i[5:0])) else $error("scale not written");
    chk_launch_busy: assert property (host_wr_i && host_addr_i == {CHANNEL, 8'h25}
        && host_wdata_i[7] && !access_busy_o |=> access_busy_o[*2] ##1 !access_busy_o)
        else $error("launch did not run");
    chk_busy_ends: assert property (access_busy_o |-> ##[1:2] !access_busy_o)
        else $error("access stuck busy");
    chk_nom_t1: assert property (template_select_i inside {[4'h2:4'h8]}
        |=> nominal_scale_o == 6'h36 && scale_step_o == 12'd200) else $error("t1 nominal");
    chk_nom_7db5: assert property (template_select_i == 4'h9
        |=> nominal_scale_o == 6'h11 && scale_step_o == 12'd625) else $error("7.5 dB nominal");
    chk_nom_15db: assert property (template_select_i == 4'ha
        |=> nominal_scale_o == 6'h08 && scale_step_o == 12'd1250) else $error("15 dB nominal");
    chk_nom_22db5: assert property (template_select_i == 4'hb
        |=> nominal_scale_o == 6'h04 && scale_step_o == 12'd2500) else $error("22.5 dB nominal");
    chk_nom_e1: assert property (template_select_i inside {4'h0, 4'h1}
        |=> nominal_scale_o == 6'h21 && scale_step_o == 12'd300) else $error("e1 nominal");
    chk_ja_meas: assert property (wr_ja |=> ##1 jitter_measure_mode_o == $past(host_wdata_i[5], 2))
        else $error("measure mode");
    chk_ja_wide: assert property (wr_ja |=> ##1 atten_wide_bw_mode_o == $past(host_wdata_i[4], 2))
        else $error("wide mode");
    chk_ja_enable: assert property (wr_ja |=> ##1 rx_atten_enable_o == $past(host_wdata_i[3], 2))
        else $error("atten enable");
    chk_ja_depth: assert property (wr_ja |=> ##1 rx_atten_depth_o == $past(host_wdata_i[2:1], 2)
        && rx_atten_depth_bits_o == (rx_atten_depth_o == 2'h0 ? 8'h80 : rx_atten_depth_o == 2'h1 ? 8'h40 : 8'h20))
        else $error("atten depth");
    chk_ja_corner: assert property (wr_ja |=> ##1 rx_atten_corner_select_o == $past(host_wdata_i[0], 2))
        else $error("corner select");
endmodule : lcpj_config_props

bind lcpj_config lcpj_config_props #(.CHANNEL(CHANNEL), .SCALE_W(SCALE_W)) u_props (
    .core_clk_i, .reset_i, .host_addr_i, .host_wr_i, .host_wdata_i, .template_select_i,
    .amplitude_scale_o, .nominal_scale_o, .scale_step_o, .access_busy_o, .jitter_measure_mode_o,
    .atten_wide_bw_mode_o, .rx_atten_enable_o, .rx_atten_depth_o, .rx_atten_depth_bits_o,
    .rx_atten_corner_select_o
);
`default_nettype wire

// ### tb/lcpj_config_tb.sv
// Self-checking bench for the channel configuration bank.
// Assumes channel 0 and one-cycle host strobes.
`default_nettype none
module lcpj_config_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import lcpj_pkg::*;
    logic          core_clk_i, reset_i, host_wr_i, host_rd_i, host_rdata_valid_o, access_busy_o;
    logic          jitter_measure_mode_o, atten_wide_bw_mode_o, rx_atten_enable_o, rx_atten_corner_select_o;
    logic [7:0]    rx_atten_depth_bits_o;
    logic [11:0]   host_addr_i;
    logic [3:0]    template_select_i;
    logic [5:0]    shaper_addr_i, amplitude_scale_o, nominal_scale_o;
    logic [12:0]   shaper_sample_o;
    logic [11:0]   scale_step_o;
    logic [1:0]    rx_atten_depth_o;
    lcpj_byte_type host_wdata_i, host_rdata_o, rd_val;
    int            mismatches, n_checks;

    lcpj_config dut (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .host_addr_i(host_addr_i), .host_wr_i(host_wr_i),
        .host_rd_i(host_rd_i), .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o),
        .host_rdata_valid_o(host_rdata_valid_o), .template_select_i(template_select_i),
        .shaper_addr_i(shaper_addr_i), .shaper_sample_o(shaper_sample_o), .amplitude_scale_o(amplitude_scale_o),
        .nominal_scale_o(nominal_scale_o), .scale_step_o(scale_step_o), .access_busy_o(access_busy_o),
        .jitter_measure_mode_o(jitter_measure_mode_o), .atten_wide_bw_mode_o(atten_wide_bw_mode_o),
        .rx_atten_enable_o(rx_atten_enable_o), .rx_atten_depth_o(rx_atten_depth_o),
        .rx_atten_depth_bits_o(rx_atten_depth_bits_o), .rx_atten_corner_select_o(rx_atten_corner_select_o)
    );

    task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude

    task automatic wr(input logic [11:0] a, input lcpj_byte_type d);
        @(posedge core_clk_i);
        #1;
        host_addr_i = a;
        host_wdata_i = d;
        host_wr_i = 1'b1;
        @(posedge core_clk_i);
        #1;
        host_wr_i = 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a);
        @(posedge core_clk_i);
        #1;
        host_addr_i = a;
        host_rd_i = 1'b1;
        @(posedge core_clk_i);
        #1;
        host_rd_i = 1'b0;
        chk("rdata_valid", 18'h1, host_rdata_valid_o);
        rd_val = host_rdata_o;
    endtask : rd

    // Poll the launch bit; a bounded poll guards against a hang
    task automatic wait_idle();
        for (int i = 0; i < 8; i++) begin
            rd(12'h025);
            if (rd_val[7] === 1'b0) return;
        end
        chk("launch_clear", 18'h0, 18'h1);
        conclude();
    endtask : wait_idle

    task automatic t_reset();
        rd(12'h024);
        chk("scale_rst", 18'h21, rd_val);
        rd(12'h025);
        chk("access_rst", 18'h0, rd_val);
        rd(12'h027);
        chk("jitter_rst", 18'h10, rd_val);
        chk("depth_bits_rst", 18'h80, rx_atten_depth_bits_o);
    endtask : t_reset

    task automatic t_scale();
        wr(12'h024, 8'hff);
        wr(12'h124, 8'h00);
        rd(12'h024);
        chk("scale_rd", 18'h3f, rd_val);
        chk("scale_out", 18'h3f, amplitude_scale_o);
        rd(12'h124);
        chk("other_chan", 18'h0, rd_val);
        rd(12'h028);
        chk("unmapped", 18'h0, rd_val);
    endtask : t_scale

    task automatic t_nominal();
        logic [3:0]  cd[8] = '{4'h0, 4'h1, 4'h2, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb};
        logic [17:0] ex[8] = '{{6'h21, 12'd300}, {6'h21, 12'd300}, {6'h36, 12'd200}, {6'h36, 12'd200},
                               {6'h36, 12'd200}, {6'h11, 12'd625}, {6'h08, 12'd1250}, {6'h04, 12'd2500}};
        for (int k = 0; k < 8; k++) begin
            template_select_i = cd[k];
            repeat (2) @(posedge core_clk_i);
            #1;
            chk("nominal", ex[k], {nominal_scale_o, scale_step_o});
        end
    endtask : t_nominal

    task automatic t_ram();
        logic [5:0] ad[3] = '{6'h00, 6'h3f, 6'h15};
        logic [6:0] vl[3] = '{7'h7f, 7'h01, 7'h2a};
        for (int k = 0; k < 3; k++) begin
            wr(12'h026, {1'b0, vl[k]});
            wr(12'h025, {2'b10, ad[k]});
            chk("busy", 18'h1, access_busy_o);
            // A launch while busy must be dropped whole
            if (k == 0) begin
                wr(12'h025, 8'hff);
            end
            wait_idle();
            chk("access_reg", {2'b00, ad[k]}, rd_val);
        end
        wr(12'h026, 8'h00);
        for (int k = 0; k < 3; k++) begin
            wr(12'h025, {2'b11, ad[k]});
            wait_idle();
            rd(12'h026);
            chk("ram_read", vl[k], rd_val);
            template_select_i = 4'hc;
            shaper_addr_i = ad[k];
            repeat (2) @(posedge core_clk_i);
            #1;
            chk("shaper_scaled", vl[k] * 13'h3f, shaper_sample_o);
            template_select_i = 4'h0;
            repeat (2) @(posedge core_clk_i);
            #1;
            chk("shaper_raw", vl[k], shaper_sample_o);
        end
    endtask : t_ram

    task automatic t_jitter();
        lcpj_byte_type vs[4] = '{8'hff, 8'h00, 8'h2a, 8'h15};
        logic [7:0]    bits;
        for (int k = 0; k < 4; k++) begin
            bits = vs[k][2:1] == 2'h0 ? 8'h80 : vs[k][2:1] == 2'h1 ? 8'h40 : 8'h20;
            wr(12'h027, vs[k]);
            rd(12'h027);
            chk("jitter_rd", vs[k] & 8'h3f, rd_val);
            chk("jitter_out", {vs[k][5:0], bits}, {jitter_measure_mode_o, atten_wide_bw_mode_o,
                rx_atten_enable_o, rx_atten_depth_o, rx_atten_corner_select_o, rx_atten_depth_bits_o});
        end
    endtask : t_jitter

    initial begin
        core_clk_i = 1'b0;
        forever #25 core_clk_i = ~core_clk_i;
    end

    initial begin
        mismatches = 0;
        n_checks = 0;
        reset_i = 1'b1;
        host_wr_i = 1'b0;
        host_rd_i = 1'b0;
        host_addr_i = 12'h000;
        host_wdata_i = 8'h00;
        template_select_i = 4'h0;
        shaper_addr_i = 6'h00;
        repeat (10) @(posedge core_clk_i);
        #1;
        reset_i = 1'b0;
        t_reset();
        t_scale();
        t_nominal();
        t_ram();
        t_jitter();
        conclude();
    end
endmodule : lcpj_config_tb
`default_nettype wire
